//--- gicp_port.sv
`include "gicp_defines.svh"

module gicp_port #(
    parameter int unsigned STUCK_CYCLES  = `GICP_STUCK_CYCLES,
    parameter int unsigned UPDATE_CYCLES = `GICP_UPDATE_CYCLES
) (
    input  wire  logic          clock,
    input  wire  logic          resetn,
    input  wire  logic          link_clock,
    input  wire  logic          scl_in,
    input  wire  logic          sda_in,
    output logic                scl_out,
    output logic                scl_oe,
    output logic                sda_out,
    output logic                sda_oe,
    input  wire  logic          normal_mode,
    input  wire  logic [15:0]   gauge_data [0:28],
    output logic [15:0]         control_port,
    output logic [15:0]         at_rate_setpoint,
    output logic                control_strobe,
    output logic                sleep_req
);
    // system side: counts the 2 s stuck timeout on the system clock, the link clock's sibling
    logic [1:0]  scl_s_reg, sda_s_reg;
    gicp_pkg::gicp_lines_t lines_reg;
    gicp_pkg::gicp_state_t state_reg;
    logic [2:0]  bit_cnt_reg;
    logic [7:0]  shift_reg;
    logic [7:0]  ptr_reg;
    logic        rd_reg, cmd_phase_reg, got_data_reg, ack_ok_reg, sleep_reg;
    logic [31:0] stuck_cnt_reg, upd_cnt_reg;
    logic        released_reg, full_reg;
    logic [15:0] shadow_reg [0:28];
    gicp_pkg::gicp_wr_t wr_reg;

    // index of a command location within the shadow table
    function automatic logic [4:0] slot(input logic [7:0] loc);
        slot = (loc[5:1] > 5'd28) ? 5'd28 : loc[5:1];
    endfunction : slot

    function automatic logic writable(input logic [7:0] loc);
        writable = (loc[7:2] == 6'h00);
    endfunction : writable

    function automatic logic mapped(input logic [7:0] loc);
        mapped = (loc <= 8'h39) && !(loc >= 8'h26 && loc <= 8'h27)
            && !(loc >= 8'h30 && loc <= 8'h33);
    endfunction : mapped

    // byte served for a location; unmapped locations read as zero
    function automatic logic [7:0] rd_byte(input logic [7:0] loc);
        rd_byte = !mapped(loc) ? 8'h00
            : (loc[0] ? shadow_reg[slot(loc)][15:8] : shadow_reg[slot(loc)][7:0]);
    endfunction : rd_byte

    // two-flop synchronisers on the link clock
    always_ff @(posedge link_clock or negedge resetn) begin
        if (!resetn) begin
            scl_s_reg <= 2'b11;
            sda_s_reg <= 2'b11;
        end else begin
            scl_s_reg <= {scl_s_reg[0], scl_in};
            sda_s_reg <= {sda_s_reg[0], sda_in};
        end
    end

    always_ff @(posedge link_clock or negedge resetn) begin
        if (!resetn) begin
            lines_reg <= '1;
        end else begin
            lines_reg <= '{scl: scl_s_reg[1], sda: sda_s_reg[1]};
        end
    end

    wire scl_now = scl_s_reg[1];
    wire sda_now = sda_s_reg[1];
    wire start_c = lines_reg.scl && scl_now && lines_reg.sda && !sda_now;
    wire stop_c  = lines_reg.scl && scl_now && !lines_reg.sda && sda_now;
    wire scl_rise = !lines_reg.scl && scl_now;
    wire scl_fall = lines_reg.scl && !scl_now;

    // stuck-bus timeout, measured on the system clock via synchronised levels
    logic [1:0] scl_c_reg, sda_c_reg, rel_ack_reg;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            scl_c_reg <= 2'b11;
            sda_c_reg <= 2'b11;
        end else begin
            scl_c_reg <= {scl_c_reg[0], scl_in};
            sda_c_reg <= {sda_c_reg[0], sda_in};
        end
    end

    logic timeout_tgl_reg;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            stuck_cnt_reg   <= 32'h0000_0000;
            timeout_tgl_reg <= 1'b0;
            sleep_reg       <= 1'b0;
        end else if (scl_c_reg[1] && sda_c_reg[1]) begin
            stuck_cnt_reg <= 32'h0000_0000;
            sleep_reg     <= 1'b0;
        end else if (stuck_cnt_reg == STUCK_CYCLES - 1) begin
            stuck_cnt_reg   <= stuck_cnt_reg + 32'h0000_0001;
            timeout_tgl_reg <= ~timeout_tgl_reg;
        end else if (stuck_cnt_reg == STUCK_CYCLES + 3) begin
            sleep_reg <= 1'b1;
        end else begin
            stuck_cnt_reg <= stuck_cnt_reg + 32'h0000_0001;
        end
    end

    // timeout toggle crosses into the link domain
    logic [2:0] tgl_s_reg;
    always_ff @(posedge link_clock or negedge resetn) begin
        if (!resetn) begin
            tgl_s_reg <= 3'b000;
        end else begin
            tgl_s_reg <= {tgl_s_reg[1:0], timeout_tgl_reg};
        end
    end
    wire timeout_ev = tgl_s_reg[2] ^ tgl_s_reg[1];

    // serial engine on the link clock
    always_ff @(posedge link_clock or negedge resetn) begin
        if (!resetn) begin
            state_reg     <= gicp_pkg::GICP_IDLE;
            bit_cnt_reg   <= 3'd0;
            shift_reg     <= 8'h00;
            ptr_reg       <= 8'h00;
            rd_reg        <= 1'b0;
            cmd_phase_reg <= 1'b0;
            got_data_reg  <= 1'b0;
            ack_ok_reg    <= 1'b0;
            sda_oe        <= 1'b0;
            wr_reg        <= '0;
            released_reg  <= 1'b0;
            full_reg      <= 1'b0;
        end else begin
            wr_reg.valid <= 1'b0;
            if (timeout_ev) begin
                state_reg    <= gicp_pkg::GICP_IDLE;
                sda_oe       <= 1'b0;
                released_reg <= 1'b1;
            end else if (start_c) begin
                state_reg    <= gicp_pkg::GICP_ADDR;
                bit_cnt_reg  <= 3'd0;
                full_reg     <= 1'b0;
                sda_oe       <= 1'b0;
                released_reg <= 1'b0;
            end else if (stop_c || released_reg) begin
                state_reg <= gicp_pkg::GICP_IDLE;
                sda_oe    <= 1'b0;
            end else begin
                case (state_reg)
                    gicp_pkg::GICP_IDLE: begin
                        sda_oe <= 1'b0;
                    end
                    gicp_pkg::GICP_ADDR, gicp_pkg::GICP_WRX: begin
                        if (scl_rise) begin
                            shift_reg   <= {shift_reg[6:0], sda_now};
                            bit_cnt_reg <= bit_cnt_reg + 3'd1;
                            full_reg    <= (bit_cnt_reg == 3'd7);
                        end
                        if (scl_fall && full_reg) begin
                            full_reg <= 1'b0;
                            if (state_reg == gicp_pkg::GICP_ADDR) begin
                                if (shift_reg[7:1] == `GICP_TARGET_ADDR && normal_mode) begin
                                    sda_oe        <= 1'b1;
                                    rd_reg        <= shift_reg[0];
                                    cmd_phase_reg <= !shift_reg[0];
                                    got_data_reg  <= 1'b0;
                                    state_reg     <= gicp_pkg::GICP_AACK;
                                end else begin
                                    state_reg <= gicp_pkg::GICP_IDLE;
                                end
                            end else if (cmd_phase_reg) begin
                                cmd_phase_reg <= 1'b0;
                                ptr_reg       <= shift_reg;
                                sda_oe        <= (shift_reg <= `GICP_CMD_MAX);
                                state_reg     <= gicp_pkg::GICP_WACK;
                            end else begin
                                ack_ok_reg <= !got_data_reg && writable(ptr_reg);
                                sda_oe     <= !got_data_reg && writable(ptr_reg);
                                if (!got_data_reg && writable(ptr_reg)) begin
                                    wr_reg <= '{valid: 1'b1, loc: ptr_reg, data: shift_reg};
                                    ptr_reg <= ptr_reg + 8'd1;
                                end
                                got_data_reg <= 1'b1;
                                state_reg    <= gicp_pkg::GICP_WACK;
                            end
                        end
                    end
                    gicp_pkg::GICP_AACK: begin
                        if (scl_fall) begin
                            bit_cnt_reg <= 3'd0;
                            if (rd_reg) begin
                                shift_reg <= rd_byte(ptr_reg);
                                state_reg <= gicp_pkg::GICP_RTX;
                                sda_oe    <= 1'b1;
                            end else begin
                                sda_oe    <= 1'b0;
                                state_reg <= gicp_pkg::GICP_WRX;
                            end
                        end
                    end
                    gicp_pkg::GICP_WACK: begin
                        if (scl_fall) begin
                            sda_oe      <= 1'b0;
                            bit_cnt_reg <= 3'd0;
                            state_reg   <= gicp_pkg::GICP_WRX;
                        end
                    end
                    gicp_pkg::GICP_RTX: begin
                        if (scl_fall) begin
                            shift_reg   <= {shift_reg[6:0], 1'b0};
                            bit_cnt_reg <= bit_cnt_reg + 3'd1;
                            if (bit_cnt_reg == 3'd7) begin
                                sda_oe    <= 1'b0;
                                state_reg <= gicp_pkg::GICP_RACK;
                            end
                        end
                    end
                    gicp_pkg::GICP_RACK: begin
                        if (scl_rise) begin
                            if (!sda_now) begin
                                ptr_reg <= ptr_reg + 8'd1;
                            end
                            ack_ok_reg <= !sda_now;
                        end
                        if (scl_fall) begin
                            bit_cnt_reg <= 3'd0;
                            if (ack_ok_reg) begin
                                shift_reg <= rd_byte(ptr_reg);
                                sda_oe    <= 1'b1;
                                state_reg <= gicp_pkg::GICP_RTX;
                            end else begin
                                state_reg <= gicp_pkg::GICP_IDLE;
                            end
                        end
                    end
                    default: state_reg <= gicp_pkg::GICP_IDLE;
                endcase
            end
        end
    end

    // read data bit taken from shift_reg[7] while shifting; acknowledge drives low
    always_ff @(posedge link_clock or negedge resetn) begin
        if (!resetn) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= (state_reg == gicp_pkg::GICP_RTX) ? shift_reg[7] : 1'b0;
        end
    end

    // the engine never stretches in this build, so the clock line stays released
    always_ff @(posedge link_clock or negedge resetn) begin
        if (!resetn) begin
            scl_out <= 1'b0;
            scl_oe  <= 1'b0;
        end else begin
            scl_out <= 1'b0;
            scl_oe  <= 1'b0;
        end
    end

    // written bytes cross into the system domain by toggle handshake
    logic       wr_tgl_reg;
    logic [7:0] wr_loc_reg, wr_dat_reg;
    always_ff @(posedge link_clock or negedge resetn) begin
        if (!resetn) begin
            wr_tgl_reg <= 1'b0;
            wr_loc_reg <= 8'h00;
            wr_dat_reg <= 8'h00;
        end else if (wr_reg.valid) begin
            wr_tgl_reg <= ~wr_tgl_reg;
            wr_loc_reg <= wr_reg.loc;
            wr_dat_reg <= wr_reg.data;
        end
    end

    logic [2:0] wt_s_reg;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wt_s_reg <= 3'b000;
        end else begin
            wt_s_reg <= {wt_s_reg[1:0], wr_tgl_reg};
        end
    end
    wire wr_ev = wt_s_reg[2] ^ wt_s_reg[1];

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            control_port     <= `GICP_RESET_WORD;
            at_rate_setpoint <= `GICP_RESET_WORD;
            control_strobe   <= 1'b0;
        end else begin
            control_strobe <= 1'b0;
            if (wr_ev) begin
                case (wr_loc_reg)
                    8'h00: control_port[7:0] <= wr_dat_reg;
                    8'h01: begin
                        control_port[15:8] <= wr_dat_reg;
                        control_strobe     <= 1'b1;
                    end
                    8'h02: at_rate_setpoint[7:0]  <= wr_dat_reg;
                    8'h03: at_rate_setpoint[15:8] <= wr_dat_reg;
                    default: control_strobe <= 1'b0;
                endcase
            end
        end
    end

    // snapshot refreshed once per second; link reads see the stable copy
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            upd_cnt_reg <= 32'h0000_0000;
            for (int i = 0; i < 29; i++) shadow_reg[i] <= `GICP_RESET_WORD;
        end else if (upd_cnt_reg == UPDATE_CYCLES - 1) begin
            upd_cnt_reg <= 32'h0000_0000;
            for (int i = 0; i < 29; i++) shadow_reg[i] <= gauge_data[i];
            shadow_reg[0] <= control_port;
            shadow_reg[1] <= at_rate_setpoint;
        end else begin
            upd_cnt_reg <= upd_cnt_reg + 32'h0000_0001;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sleep_req <= 1'b0;
        end else begin
            sleep_req <= sleep_reg;
        end
    end

    cmd_nack_a: assert property (@(posedge link_clock) disable iff (!resetn)
        (state_reg == gicp_pkg::GICP_WACK && $past(cmd_phase_reg) && ptr_reg > 8'h7f)
        |-> !sda_oe) else $error("command above range acknowledged");
    ro_nack_a: assert property (@(posedge link_clock) disable iff (!resetn)
        $rose(wr_reg.valid) |-> writable(wr_reg.loc)) else $error("read-only write");
    sleep_after_a: assert property (@(posedge clock) disable iff (!resetn)
        $rose(sleep_reg) |-> $past(!(scl_c_reg[1] && sda_c_reg[1])))
        else $error("sleep without stuck line");
    addr_ack_a: assert property (@(posedge link_clock) disable iff (!resetn)
        (state_reg == gicp_pkg::GICP_AACK && $past(state_reg) == gicp_pkg::GICP_ADDR) |-> sda_oe)
        else $error("address not acknowledged");
    ptr_step_a: assert property (@(posedge link_clock) disable iff (!resetn)
        (state_reg == gicp_pkg::GICP_RACK && scl_rise && !sda_now && !timeout_ev && !released_reg)
        |=> ptr_reg == 8'($past(ptr_reg) + 8'd1)) else $error("pointer did not advance");
    line_release_a: assert property (@(posedge link_clock) disable iff (!resetn)
        timeout_ev |=> !sda_oe && !scl_oe) else $error("lines held after timeout");
    sequence tmo_quiet_s;
        timeout_ev ##1 !start_c;
    endsequence
    idle_after_a: assert property (@(posedge link_clock) disable iff (!resetn)
        tmo_quiet_s |=> state_reg == gicp_pkg::GICP_IDLE) else $error("busy after timeout");
endmodule : gicp_port

//--- gicp_defines.svh
`ifndef GICP_DEFINES_SVH
`define GICP_DEFINES_SVH

`define GICP_TARGET_ADDR      7'h55
`define GICP_CMD_MAX          8'h7f
`define GICP_OFS_CONTROL      8'h00
`define GICP_OFS_AT_RATE      8'h02
`define GICP_OFS_UNF_CHARGE   8'h04
`define GICP_OFS_THERMAL      8'h06
`define GICP_OFS_CELL_MV      8'h08
`define GICP_OFS_STATUS       8'h0a
`define GICP_OFS_NOM_AVAIL    8'h0c
`define GICP_OFS_FULL_AVAIL   8'h0e
`define GICP_OFS_REMAIN       8'h10
`define GICP_OFS_FULL_CHG     8'h12
`define GICP_OFS_AVG_I        8'h14
`define GICP_OFS_TO_EMPTY     8'h16
`define GICP_OFS_FILT_FULL    8'h18
`define GICP_OFS_STBY_I       8'h1a
`define GICP_OFS_UNF_FULL     8'h1c
`define GICP_OFS_MAX_LOAD     8'h1e
`define GICP_OFS_UNF_REMAIN   8'h20
`define GICP_OFS_FILT_REMAIN  8'h22
`define GICP_OFS_AVG_P        8'h24
`define GICP_OFS_DIE_THERMAL  8'h28
`define GICP_OFS_CYCLES       8'h2a
`define GICP_OFS_CHARGE_PCT   8'h2c
`define GICP_OFS_HEALTH_PCT   8'h2e
`define GICP_OFS_PASSED       8'h34
`define GICP_OFS_DEPTH_ZERO   8'h36
`define GICP_OFS_SELF_DSG     8'h38
`define GICP_RESET_WORD       16'h0000
`define GICP_CLOCK_HZ         40000000
`define GICP_STUCK_TIMEOUT_MS 2000
`define GICP_STUCK_CYCLES     ((`GICP_CLOCK_HZ / 1000) * `GICP_STUCK_TIMEOUT_MS)
`define GICP_UPDATE_MS        1000
`define GICP_UPDATE_CYCLES    ((`GICP_CLOCK_HZ / 1000) * `GICP_UPDATE_MS)

`endif

//--- gicp_pkg.sv
package gicp_pkg;
    typedef enum logic [6:0] {
        GICP_IDLE = 7'b000_0001,
        GICP_ADDR = 7'b000_0010,
        GICP_AACK = 7'b000_0100,
        GICP_WRX  = 7'b000_1000,
        GICP_WACK = 7'b001_0000,
        GICP_RTX  = 7'b010_0000,
        GICP_RACK = 7'b100_0000
    } gicp_state_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] loc;
        logic [7:0] data;
    } gicp_wr_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } gicp_lines_t;
endpackage : gicp_pkg

//--- gicp_host_model.sv
module gicp_host_model #(
    parameter int Q_NS   = 250,
    parameter int GAP_NS = 2000
) (
    output logic      scl_low,
    output logic      sda_low,
    input  wire logic scl,
    input  wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end

    task automatic drive_lines(input logic scl_l, input logic sda_l);
        scl_low = scl_l;
        sda_low = sda_l;
    endtask : drive_lines

    // release clock, then wait while the device stretches it
    task automatic rise_scl();
        int n;
        n = 0;
        scl_low = 1'b0;
        while (scl !== 1'b1 && n < 400000) begin
            #10;
            n++;
        end
        #(Q_NS);
    endtask : rise_scl

    task automatic bit_io(input logic b, output logic r);
        sda_low = ~b;
        #(Q_NS);
        rise_scl();
        r = sda;
        #(Q_NS);
        scl_low = 1'b1;
        #(Q_NS);
    endtask : bit_io

    task automatic start_cond();
        sda_low = 1'b0;
        #(Q_NS);
        rise_scl();
        sda_low = 1'b1;
        #(Q_NS);
        scl_low = 1'b1;
        #(Q_NS);
    endtask : start_cond

    // idle gap after each transfer, shortened from the real waiting times
    task automatic stop_cond();
        sda_low = 1'b1;
        #(Q_NS);
        rise_scl();
        sda_low = 1'b0;
        #(GAP_NS);
    endtask : stop_cond

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r);
        end
        bit_io(1'b1, r);
        ack = (r === 1'b0);
    endtask : send_byte

    task automatic recv_byte(input logic give_ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(~give_ack, r);
    endtask : recv_byte
endmodule : gicp_host_model

//--- test_gauge_i2c_command_port.sv
module test_gauge_i2c_command_port;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int STUCK = 2000;
    localparam int UPD   = 50;

    logic        clock;
    logic        resetn;
    logic        link_clock;
    logic        normal_mode;
    logic [15:0] gauge_data [0:28];
    logic        scl_out;
    logic        scl_oe;
    logic        sda_out;
    logic        sda_oe;
    logic [15:0] control_port;
    logic [15:0] at_rate_setpoint;
    logic        control_strobe;
    logic        sleep_req;
    logic        h_scl_low;
    logic        h_sda_low;
    wire         scl_line;
    wire         sda_line;
    int          error_cnt;
    int          samples_checked;
    int          strobe_cnt;
    int          ctl_w;
    int          atr_w;
    int          ptr;
    int          gword [29];
    logic [3:0]  acks;
    logic [7:0]  b0;
    logic [7:0]  b1;
    logic        a;

    // open-drain lines with pull-ups
    assign scl_line = !((scl_oe && !scl_out) || h_scl_low);
    assign sda_line = !((sda_oe && !sda_out) || h_sda_low);

    gicp_port #(.STUCK_CYCLES(STUCK), .UPDATE_CYCLES(UPD)) i_dut (
        .clock            (clock),
        .resetn           (resetn),
        .link_clock       (link_clock),
        .scl_in           (scl_line),
        .sda_in           (sda_line),
        .scl_out          (scl_out),
        .scl_oe           (scl_oe),
        .sda_out          (sda_out),
        .sda_oe           (sda_oe),
        .normal_mode      (normal_mode),
        .gauge_data       (gauge_data),
        .control_port     (control_port),
        .at_rate_setpoint (at_rate_setpoint),
        .control_strobe   (control_strobe),
        .sleep_req        (sleep_req)
    );

    gicp_host_model i_host (
        .scl_low (h_scl_low),
        .sda_low (h_sda_low),
        .scl     (scl_line),
        .sda     (sda_line)
    );

    always #12.5 clock = ~clock;

    initial begin
        link_clock = 1'b0;
        #7;
        forever #40 link_clock = ~link_clock;
    end

    always @(posedge clock) begin
        if (control_strobe === 1'b1) begin
            strobe_cnt <= strobe_cnt + 1;
        end
    end

    // reference byte for a command location
    function automatic int exp_byte(int loc);
        int w;
        if (loc < 2) w = ctl_w;
        else if (loc < 4) w = atr_w;
        else if (loc > 'h39 || loc == 'h26 || loc == 'h27 || (loc >= 'h30 && loc <= 'h33)) w = 0;
        else w = gword[loc / 2];
        return (loc % 2) ? (w >> 8) & 255 : w & 255;
    endfunction : exp_byte

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done(input string name);
        $display("test %s done, mismatches so far %0d", name, error_cnt);
    endtask : test_done

    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    task automatic write_tr(input logic [7:0] loc, input logic [7:0] d, input logic two,
                            output logic [3:0] ak);
        i_host.start_cond();
        i_host.send_byte(8'hAA, ak[3]);
        i_host.send_byte(loc, ak[2]);
        i_host.send_byte(d, ak[1]);
        ak[0] = 1'b0;
        if (two) i_host.send_byte(~d, ak[0]);
        i_host.stop_cond();
    endtask : write_tr

    task automatic read_tr(input logic [7:0] loc, input int n, input logic quick);
        logic       ak;
        logic [7:0] d;
        i_host.start_cond();
        if (!quick) begin
            ptr = int'(loc);
            i_host.send_byte(8'hAA, ak);
            check(16'(ak), 16'h0001);
            i_host.send_byte(loc, ak);
            check(16'(ak), 16'h0001);
            i_host.start_cond();
        end
        i_host.send_byte(8'hAB, ak);
        check(16'(ak), 16'h0001);
        for (int k = 0; k < n; k++) begin
            i_host.recv_byte(k < n - 1, d);
            check({8'h00, d}, 16'(exp_byte(ptr)));
            ptr++;
        end
        i_host.stop_cond();
    endtask : read_tr

    initial begin
        clock = 1'b0;
        resetn = 1'b0;
        normal_mode = 1'b1;
        error_cnt = 0;
        samples_checked = 0;
        strobe_cnt = 0;
        ctl_w = 0;
        atr_w = 0;
        ptr = 0;
        void'($urandom(11));
        for (int k = 0; k < 29; k++) begin
            gword[k] = int'($urandom & 32'h0000_ffff);
            gauge_data[k] = 16'(gword[k]);
        end
        repeat (10) @(posedge clock);
        #2 resetn = 1'b1;
        repeat (4 * UPD) @(posedge clock);
        check(control_port, 16'h0000);
        check(at_rate_setpoint, 16'h0000);
        // wrong mode, right address, wrong address
        for (int k = 0; k < 3; k++) begin
            @(posedge clock);
            #2 normal_mode = (k != 0);
            i_host.start_cond();
            i_host.send_byte(k == 2 ? 8'hA8 : 8'hAA, a);
            i_host.stop_cond();
            check(16'(a), 16'(k == 1));
        end
        test_done("address");
        b0 = 8'($urandom);
        b1 = 8'($urandom);
        write_tr(8'h02, b0, 1'b1, acks);
        check(16'(acks), 16'h000e);
        write_tr(8'h03, b1, 1'b0, acks);
        check(16'(acks), 16'h000e);
        atr_w = int'({b1, b0});
        check(at_rate_setpoint, 16'(atr_w));
        ptr = 4;
        read_tr(8'h00, 1, 1'b1);
        test_done("at_rate");
        b0 = 8'($urandom);
        b1 = 8'($urandom);
        write_tr(8'h00, b0, 1'b0, acks);
        write_tr(8'h01, b1, 1'b0, acks);
        ctl_w = int'({b1, b0});
        check(control_port, 16'(ctl_w));
        check(16'(strobe_cnt), 16'h0001);
        ptr = 2;
        read_tr(8'h00, 2, 1'b1);
        test_done("control");
        write_tr(8'h08, b0, 1'b0, acks);
        check(16'(acks), 16'h000c);
        for (int k = 0; k < 2; k++) begin
            i_host.start_cond();
            i_host.send_byte(8'hAA, a);
            i_host.send_byte(k == 1 ? 8'hff : 8'h80, a);
            i_host.stop_cond();
            check(16'(a), 16'h0000);
        end
        test_done("refusals");
        read_tr(8'h08, 2, 1'b0);
        read_tr(8'h7e, 2, 1'b0);
        read_tr(8'h25, 4, 1'b0);
        for (int k = 0; k < 6; k++) begin
            b0 = 8'($urandom % 120);
            read_tr(b0, 1 + int'($urandom % 4), 1'b0);
        end
        test_done("reads");
        // stall the bus during the address acknowledge
        i_host.start_cond();
        for (int i = 7; i >= 0; i--) begin
            i_host.bit_io(i % 2 == 1, a);
        end
        i_host.drive_lines(1'b1, 1'b0);
        repeat (40) @(posedge clock);
        check(16'(sda_oe), 16'h0001);
        repeat (2 * STUCK) @(posedge clock);
        check({14'h0000, sda_oe, scl_oe}, 16'h0000);
        check(16'(sleep_req), 16'h0001);
        i_host.drive_lines(1'b0, 1'b0);
        repeat (40) @(posedge clock);
        read_tr(8'h06, 2, 1'b0);
        test_done("timeout");
        complete_run();
    end

    initial begin
        repeat (80000) @(posedge clock);
        error_cnt++;
        complete_run();
    end
endmodule : test_gauge_i2c_command_port
